//--- axil_reg_slave.sv
// AXI4-Lite slave that turns bus transfers into byte register accesses
`timescale 1ns/10ps
`default_nettype none
module axil_reg_slave (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [4:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [4:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic wr_en,
	output logic [4:0] wr_addr,
	output logic [7:0] wr_data,
	output logic [4:0] rd_addr,
	input wire logic [7:0] rd_data
);
	typedef struct packed {
		logic awready, wready, arready, aw_have, w_have, strb0, bvalid, rvalid, ar_pend, wr_en;
		logic [4:0] aw_addr, ar_addr, wr_addr;
		logic [7:0] w_data, wr_data;
		logic [1:0] bresp, rresp;
		logic [31:0] rdata;
	} slv_t;
	slv_t q, d;

	always_comb begin
		d = q;
		d.wr_en = 1'b0;
		if (q.awready && awvalid) begin
			d.aw_have = 1'b1;
			d.aw_addr = awaddr;
		end
		if (q.wready && wvalid) begin
			d.w_have = 1'b1;
			d.w_data = wdata[7:0];
			d.strb0 = wstrb[0];
		end
		if (q.bvalid && bready)
			d.bvalid = 1'b0;
		// Both halves held: commit once, answer next edge
		if (q.aw_have && q.w_have && !q.bvalid) begin
			d.aw_have = 1'b0;
			d.w_have = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = flash_seq_pkg::reg_hit(q.aw_addr) ? flash_seq_pkg::RESP_OKAY : flash_seq_pkg::RESP_SLVERR;
			d.wr_en = flash_seq_pkg::reg_hit(q.aw_addr) && q.strb0;
			d.wr_addr = q.aw_addr;
			d.wr_data = q.w_data;
		end
		d.awready = !d.aw_have && !d.bvalid;
		d.wready = !d.w_have && !d.bvalid;
		if (q.arready && arvalid) begin
			d.arready = 1'b0;
			d.ar_pend = 1'b1;
			d.ar_addr = araddr;
		end
		if (q.ar_pend) begin
			d.ar_pend = 1'b0;
			d.rvalid = 1'b1;
			d.rdata = {24'h00_0000, rd_data};
			d.rresp = flash_seq_pkg::reg_hit(q.ar_addr) ? flash_seq_pkg::RESP_OKAY : flash_seq_pkg::RESP_SLVERR;
		end
		if (q.rvalid && rready) begin
			d.rvalid = 1'b0;
			d.arready = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.awready <= 1'b1;
			q.wready <= 1'b1;
			q.arready <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign awready = q.awready;
	assign wready = q.wready;
	assign arready = q.arready;
	assign bvalid = q.bvalid;
	assign bresp = q.bresp;
	assign rvalid = q.rvalid;
	assign rresp = q.rresp;
	assign rdata = q.rdata;
	assign wr_en = q.wr_en;
	assign wr_addr = q.wr_addr;
	assign wr_data = q.wr_data;
	assign rd_addr = q.ar_addr;
endmodule
`default_nettype wire

//--- flash_core_model.sv
// Core-side model: counts forced no-op and stall cycles and captures the row stream
`timescale 1ns/10ps
`default_nettype none
module flash_core_model (
	input wire logic aclk,
	input wire logic clr,
	input wire logic cpu_force_nop,
	input wire logic cpu_stall,
	input wire logic flash_word_valid,
	input wire logic [4:0] flash_word_idx,
	input wire logic [13:0] flash_word_data,
	output logic [15:0] nop_cnt,
	output logic [15:0] stall_cnt,
	output logic [15:0] word_cnt,
	output logic [13:0] row_img [32]
);
	always_ff @(posedge aclk) begin
		if (clr) begin
			nop_cnt <= '0;
			stall_cnt <= '0;
			word_cnt <= '0;
			for (int i = 0; i < 32; i++) begin
				row_img[i] <= '0;
			end
		end else begin
			// Core spends each forced slot on a no-op and waits out the stall
			if (cpu_force_nop) begin
				nop_cnt <= nop_cnt + 16'h0001;
			end
			if (cpu_stall) begin
				stall_cnt <= stall_cnt + 16'h0001;
			end
			// Flash array side: one word per valid pulse
			if (flash_word_valid) begin
				row_img[flash_word_idx] <= flash_word_data;
				word_cnt <= word_cnt + 16'h0001;
			end
		end
	end
endmodule
`default_nettype wire

//--- flash_self_erase_write.sv
// Flash self-erase and row-write sequencer with AXI4-Lite register access
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Erase acts on a whole row only; no single-word erase exists.
// - Start spends two setup cycles; core executes two no-ops meanwhile.
// - Row erase stalls the core about 2 ms; clock keeps running.
// - After erase or program the stall drops and the core resumes.
// - Programming never erases; software writes only blank words.
// - One program operation writes all 32 latches, loaded or blank.
// - Upper ten address bits pick the row, lower five the latch.
// - Every write or erase ends with all latches set to blank.
// - Each latch load takes the 14-bit data word at the addressed latch.
// - Latch-load-only set: unlock plus start only updates the addressed latch.
// - Latch-load-only clear: load addressed latch, then program whole row.
// - No write or erase starts unless the two-byte key came uninterrupted just before; a read needs no key.
// - Latch-only load forces two no-op cycles, then no stall.
// - Row program stalls the core about 2 ms, then resumes.
// - Config select picks program memory or configuration space.
// - Read and write start bits are set-only and cleared by hardware.
module flash_self_erase_write #(
	parameter logic [18:0] ERASE_CYCLES = 19'(flash_seq_pkg::ERASE_CYC),
	parameter logic [18:0] PROG_CYCLES = 19'(flash_seq_pkg::PROG_CYC)
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [4:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [4:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic cpu_force_nop,
	output logic cpu_stall,
	output logic flash_erase,
	output logic flash_prog,
	output logic flash_cfg_space,
	output logic [9:0] flash_row,
	output logic [4:0] flash_word_idx,
	output logic [13:0] flash_word_data,
	output logic flash_word_valid
);
	typedef struct packed {
		flash_seq_pkg::seq_state_t st;
		logic config_space_select, latch_load_only, free, wrerr, write_enable_bit, wr, rd;
		logic [14:0] addr;
		logic [13:0] data;
		logic got_first, armed;
		logic op_erase, op_prog, streaming;
		logic [18:0] cnt;
		logic [1:0] rd_cnt;
		logic [4:0] widx;
		logic nop, stall, fer, fpr, fcfg, fwv;
		logic [9:0] frow;
		logic [4:0] fidx;
		logic [13:0] fdat;
	} seq_t;
	seq_t q, d;

	logic wr_en;
	logic [4:0] wr_addr;
	logic [7:0] wr_data;
	logic [4:0] rd_addr;
	logic [7:0] rd_data;
	logic start;
	logic lat_ld;
	logic lat_clr;
	logic [13:0] lat_word;

	axil_reg_slave u_bus (
		.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
		.rd_addr(rd_addr), .rd_data(rd_data)
	);

	write_latch_bank u_latch (
		.aclk(aclk), .aresetn(aresetn),
		.clr(lat_clr), .ld(lat_ld),
		.ld_idx(q.addr[4:0]), .ld_data(q.data),
		.rd_idx(q.widx), .rd_word(lat_word)
	);

	// Register read view; key register reads as zero
	always_comb begin
		rd_data = 8'h00;
		if (rd_addr == flash_seq_pkg::OFS_CTRL)
			rd_data = {1'b1, q.config_space_select, q.latch_load_only, q.free, q.wrerr, q.write_enable_bit, q.wr, q.rd};
		else if (rd_addr == flash_seq_pkg::OFS_ADDR_LO)
			rd_data = q.addr[7:0];
		else if (rd_addr == flash_seq_pkg::OFS_ADDR_HI)
			rd_data = {1'b1, q.addr[14:8]};
		else if (rd_addr == flash_seq_pkg::OFS_DATA_LO)
			rd_data = q.data[7:0];
		else if (rd_addr == flash_seq_pkg::OFS_DATA_HI)
			rd_data = {2'b00, q.data[13:8]};
		else if (rd_addr == flash_seq_pkg::OFS_STATUS)
			rd_data = {5'h00, q.armed, q.stall, q.st != flash_seq_pkg::st_idle};
	end

	// A start needs the armed key, write enable and an idle sequencer
	assign start = wr_en && wr_addr == flash_seq_pkg::OFS_CTRL && wr_data[flash_seq_pkg::B_WR]
		&& q.st == flash_seq_pkg::st_idle && q.armed && wr_data[flash_seq_pkg::B_WRITE_ENABLE_BIT];
	assign lat_ld = start && !wr_data[flash_seq_pkg::B_FREE];
	assign lat_clr = q.st == flash_seq_pkg::st_done;

	always_comb begin
		d = q;
		d.fwv = 1'b0;
		if (wr_en) begin
			d.got_first = 1'b0;
			d.armed = 1'b0;
			if (wr_addr == flash_seq_pkg::OFS_KEY) begin
				if (wr_data == flash_seq_pkg::KEY_FIRST)
					d.got_first = 1'b1;
				else if (wr_data == flash_seq_pkg::KEY_SECOND && q.got_first)
					d.armed = 1'b1;
			end else if (wr_addr == flash_seq_pkg::OFS_CTRL) begin
				if (q.st == flash_seq_pkg::st_idle) begin
					d.config_space_select = wr_data[flash_seq_pkg::B_CONFIG_SPACE_SELECT];
					d.latch_load_only = wr_data[flash_seq_pkg::B_LATCH_LOAD_ONLY];
					d.free = wr_data[flash_seq_pkg::B_FREE];
					d.write_enable_bit = wr_data[flash_seq_pkg::B_WRITE_ENABLE_BIT];
				end
				// Error flag may be cleared by software, but a refused start wins
				d.wrerr = wr_data[flash_seq_pkg::B_WRERR];
				if (wr_data[flash_seq_pkg::B_WR] && !q.wr && !start)
					d.wrerr = 1'b1;
				if (wr_data[flash_seq_pkg::B_RD] && !q.rd) begin
					d.rd = 1'b1;
					d.rd_cnt = 2'(flash_seq_pkg::READ_CYC - 1);
				end
			end else if (wr_addr == flash_seq_pkg::OFS_ADDR_LO) begin
				d.addr[7:0] = wr_data;
			end else if (wr_addr == flash_seq_pkg::OFS_ADDR_HI) begin
				d.addr[14:8] = wr_data[6:0];
			end else if (wr_addr == flash_seq_pkg::OFS_DATA_LO) begin
				d.data[7:0] = wr_data;
			end else if (wr_addr == flash_seq_pkg::OFS_DATA_HI) begin
				d.data[13:8] = wr_data[5:0];
			end
		end
		if (q.rd) begin
			if (q.rd_cnt == 2'b00)
				d.rd = 1'b0;
			else
				d.rd_cnt = q.rd_cnt - 2'b01;
		end
		case (q.st)
			flash_seq_pkg::st_idle: begin
				if (start) begin
					d.st = flash_seq_pkg::st_setup;
					d.wr = 1'b1;
					d.nop = 1'b1;
					d.cnt = 19'(flash_seq_pkg::SETUP_CYC - 1);
					d.op_erase = wr_data[flash_seq_pkg::B_FREE];
					d.op_prog = !wr_data[flash_seq_pkg::B_FREE] && !wr_data[flash_seq_pkg::B_LATCH_LOAD_ONLY];
					d.fcfg = wr_data[flash_seq_pkg::B_CONFIG_SPACE_SELECT];
					d.frow = q.addr[14:5];
				end
			end
			flash_seq_pkg::st_setup: begin
				if (q.cnt == 19'h0_0000) begin
					d.nop = 1'b0;
					if (q.op_erase) begin
						d.st = flash_seq_pkg::st_erase;
						d.stall = 1'b1;
						d.fer = 1'b1;
						d.cnt = ERASE_CYCLES - 19'h0_0001;
					end else if (q.op_prog) begin
						d.st = flash_seq_pkg::st_prog;
						d.stall = 1'b1;
						d.fpr = 1'b1;
						d.streaming = 1'b1;
						d.widx = 5'h00;
						d.cnt = PROG_CYCLES - 19'h0_0001;
					end else begin
						d.st = flash_seq_pkg::st_idle;
						d.wr = 1'b0;
					end
				end else begin
					d.cnt = q.cnt - 19'h0_0001;
				end
			end
			flash_seq_pkg::st_erase: begin
				if (q.cnt == 19'h0_0000)
					d.st = flash_seq_pkg::st_done;
				else
					d.cnt = q.cnt - 19'h0_0001;
			end
			flash_seq_pkg::st_prog: begin
				// Stream every latch of the row, blank ones included
				if (q.streaming) begin
					d.fwv = 1'b1;
					d.fidx = q.widx;
					d.fdat = lat_word;
					if (q.widx == 5'h1f)
						d.streaming = 1'b0;
					else
						d.widx = q.widx + 5'h01;
				end
				if (q.cnt == 19'h0_0000 && !q.streaming)
					d.st = flash_seq_pkg::st_done;
				else if (q.cnt != 19'h0_0000)
					d.cnt = q.cnt - 19'h0_0001;
			end
			flash_seq_pkg::st_done: begin
				d.st = flash_seq_pkg::st_idle;
				d.stall = 1'b0;
				d.fer = 1'b0;
				d.fpr = 1'b0;
				d.wr = 1'b0;
				d.op_erase = 1'b0;
				d.op_prog = 1'b0;
			end
			default: begin
				d.st = flash_seq_pkg::st_idle;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			q <= '0;
		else
			q <= d;
	end

	assign cpu_force_nop = q.nop;
	assign cpu_stall = q.stall;
	assign flash_erase = q.fer;
	assign flash_prog = q.fpr;
	assign flash_cfg_space = q.fcfg;
	assign flash_row = q.frow;
	assign flash_word_idx = q.fidx;
	assign flash_word_data = q.fdat;
	assign flash_word_valid = q.fwv;

	logic [5:0] words_sent;
	always_ff @(posedge aclk) begin
		if (!aresetn || q.st == flash_seq_pkg::st_setup)
			words_sent <= 6'h00;
		else if (q.fwv)
			words_sent <= words_sent + 6'h01;
	end

	property p_setup_two;
		@(posedge aclk) disable iff (!aresetn)
		$rose(cpu_force_nop) |-> cpu_force_nop [*2] ##1 !cpu_force_nop;
	endproperty
	a_setup_two: assert property (p_setup_two) else $error("setup not two cycles");

	property p_erase_stalls;
		@(posedge aclk) disable iff (!aresetn)
		flash_erase |-> cpu_stall && !cpu_force_nop;
	endproperty
	a_erase_stalls: assert property (p_erase_stalls) else $error("erase without stall");

	property p_resume;
		@(posedge aclk) disable iff (!aresetn)
		$fell(cpu_stall) |-> q.st == flash_seq_pkg::st_idle && !q.wr && !flash_erase && !flash_prog;
	endproperty
	a_resume: assert property (p_resume) else $error("stall ended before operation closed");

	property p_no_erase_in_prog;
		@(posedge aclk) disable iff (!aresetn)
		!(flash_erase && flash_prog);
	endproperty
	a_no_erase_in_prog: assert property (p_no_erase_in_prog) else $error("erase during program");

	property p_all_words;
		@(posedge aclk) disable iff (!aresetn)
		$fell(flash_prog) |-> words_sent == 6'h20;
	endproperty
	a_all_words: assert property (p_all_words) else $error("program did not send 32 words");

	property p_row_steady;
		@(posedge aclk) disable iff (!aresetn)
		(flash_prog && $past(flash_prog)) |-> $stable(flash_row);
	endproperty
	a_row_steady: assert property (p_row_steady) else $error("row changed mid program");

	property p_blank_after;
		@(posedge aclk) disable iff (!aresetn)
		q.st == flash_seq_pkg::st_done |=> lat_word == flash_seq_pkg::BLANK_WORD;
	endproperty
	a_blank_after: assert property (p_blank_after) else $error("latches not blank after op");

	property p_load_only;
		@(posedge aclk) disable iff (!aresetn)
		(start && wr_data[flash_seq_pkg::B_LATCH_LOAD_ONLY] && !wr_data[flash_seq_pkg::B_FREE])
			|=> !cpu_stall [*3] ##1 (q.st == flash_seq_pkg::st_idle && !q.wr);
	endproperty
	a_load_only: assert property (p_load_only) else $error("latch-only load did not return");

	property p_keyed;
		@(posedge aclk) disable iff (!aresetn)
		$rose(q.wr) |-> $past(q.armed) && q.write_enable_bit;
	endproperty
	a_keyed: assert property (p_keyed) else $error("start without key or enable");

	c_erase: cover property (@(posedge aclk) disable iff (!aresetn) $fell(flash_erase));
	c_prog: cover property (@(posedge aclk) disable iff (!aresetn) $fell(flash_prog));
	c_load_only: cover property (@(posedge aclk) disable iff (!aresetn)
		$fell(cpu_force_nop) && !cpu_stall);
endmodule
`default_nettype wire

//--- flash_self_erase_write_tb.sv
// Testbench for the flash self-erase and row-write sequencer
`timescale 1ns/10ps
`default_nettype none
module flash_self_erase_write_tb;
	localparam logic [18:0] NC = 19'h0028;
	localparam logic [4:0] CT = flash_seq_pkg::OFS_CTRL;
	localparam logic [4:0] KY = flash_seq_pkg::OFS_KEY;
	localparam logic [4:0] AL = flash_seq_pkg::OFS_ADDR_LO;
	localparam logic [4:0] AH = flash_seq_pkg::OFS_ADDR_HI;
	localparam logic [4:0] DL = flash_seq_pkg::OFS_DATA_LO;
	localparam logic [4:0] ST = flash_seq_pkg::OFS_STATUS;
	localparam logic [1:0] OK = flash_seq_pkg::RESP_OKAY;
	localparam logic [1:0] SE = flash_seq_pkg::RESP_SLVERR;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic cpu_force_nop, cpu_stall, flash_erase, flash_prog, flash_cfg_space, flash_word_valid, clr;
	logic op_e, op_p, op_c, st_ok;
	logic [4:0] awaddr, araddr, flash_word_idx;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic [9:0] flash_row, op_row;
	logic [13:0] flash_word_data;
	logic [13:0] row_img [32];
	logic [15:0] nop_cnt, stall_cnt, word_cnt;
	logic [7:0] d;
	logic [15:0] ex;
	int fail_count, num_checks, cyc;

	flash_self_erase_write #(.ERASE_CYCLES(NC), .PROG_CYCLES(NC)) dut_u (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.cpu_force_nop(cpu_force_nop), .cpu_stall(cpu_stall), .flash_erase(flash_erase), .flash_prog(flash_prog),
		.flash_cfg_space(flash_cfg_space), .flash_row(flash_row), .flash_word_idx(flash_word_idx),
		.flash_word_data(flash_word_data), .flash_word_valid(flash_word_valid));
	flash_core_model core_u (.aclk(aclk), .clr(clr), .cpu_force_nop(cpu_force_nop), .cpu_stall(cpu_stall),
		.flash_word_valid(flash_word_valid), .flash_word_idx(flash_word_idx), .flash_word_data(flash_word_data),
		.nop_cnt(nop_cnt), .stall_cnt(stall_cnt), .word_cnt(word_cnt), .row_img(row_img));

	assign st_ok = (stall_cnt >= 16'(NC)) && (stall_cnt <= 16'(NC) + 16'h0001);

	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	// Remember what the sequencer drives while the core is held
	always @(posedge aclk) begin
		if (cpu_stall === 1'b1) begin
			op_e <= flash_erase;
			op_p <= flash_prog;
			op_c <= flash_cfg_space;
			op_row <= flash_row;
		end
	end

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			results();
		end
	end

	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk_resp(input string n, input logic [1:0] e, input logic [1:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk_val(input string n, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] v, input logic [1:0] er);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		wdata <= {24'h00_0000, v};
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (awready === 1'b1 && !ad) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready === 1'b1 && !wd) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk_resp("write response", er, bresp);
	endtask

	task automatic rd(input logic [4:0] a, output logic [7:0] v, output logic [1:0] rs);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		v = rdata[7:0];
		rs = rresp;
		rready <= 1'b0;
	endtask

	task automatic rchk(input string n, input logic [4:0] a, input logic [7:0] e);
		rd(a, d, r);
		chk_resp("read response", OK, r);
		chk_reg(n, e, d);
	endtask

	task automatic ld(input logic [14:0] a, input logic [13:0] v);
		wr(AL, a[7:0], OK);
		wr(AH, {1'b0, a[14:8]}, OK);
		wr(DL, v[7:0], OK);
		wr(DL + 5'h04, {2'b00, v[13:8]}, OK);
	endtask

	// Unlock keys then the start write; brk slips another write between the keys
	task automatic go(input logic [7:0] c, input logic brk);
		clr <= 1'b1;
		@(posedge aclk);
		clr <= 1'b0;
		wr(CT, c, OK);
		wr(KY, flash_seq_pkg::KEY_FIRST, OK);
		if (brk) begin
			wr(AL, 8'h00, OK);
		end
		wr(KY, flash_seq_pkg::KEY_SECOND, OK);
		wr(CT, c | 8'h02, OK);
		for (int i = 0; i < 200; i++) begin
			rd(ST, d, r);
			if (d[0] === 1'b0) begin
				break;
			end
		end
		repeat (4) @(posedge aclk);
	endtask

	initial begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 5'h00;
		araddr = 5'h00;
		wdata = 32'h0000_0000;
		wstrb = 4'h0;
		clr = 1'b1;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rchk("ctrl reset", CT, 8'h80);
		rchk("addr high reset", AH, 8'h80);
		rchk("key reads zero", KY, 8'h00);
		rchk("status reset", ST, 8'h00);
		rd(5'h1c, d, r);
		chk_resp("unmapped read", SE, r);
		wr(5'h1c, 8'hff, SE);
		wr(CT, 8'h06, OK);
		rchk("start without keys", CT, 8'h8c);
		wr(CT, 8'h01, OK);
		repeat (4) @(posedge aclk);
		rchk("read bit cleared", CT, 8'h80);
		$display("test registers done");
		ld(15'h1234, 14'h0000);
		go(8'h14, 1'b0);
		chk_val("erase no-ops", 16'h0002, nop_cnt);
		chk_val("erase stall", 16'h0001, {15'h0000, st_ok});
		chk_val("erase flag", 16'h0001, {15'h0000, op_e});
		chk_val("erase row", 16'h0091, {6'h00, op_row});
		chk_val("erase space", 16'h0000, {15'h0000, op_c});
		chk_val("erase writes nothing", 16'h0000, word_cnt);
		rd(CT, d, r);
		chk_reg("start bit cleared", 8'h00, d & 8'h02);
		rchk("status idle", ST, 8'h00);
		go(8'h54, 1'b0);
		chk_val("config space", 16'h0001, {15'h0000, op_c});
		$display("test erase done");
		ld(15'h0043, 14'h2a5c);
		go(8'h24, 1'b0);
		chk_val("load no-ops", 16'h0002, nop_cnt);
		chk_val("load no stall", 16'h0000, stall_cnt);
		chk_val("load no program", 16'h0000, word_cnt);
		ld(15'h0047, 14'h1c3e);
		go(8'h24, 1'b0);
		ld(15'h0049, 14'h0b71);
		go(8'h04, 1'b0);
		chk_val("program words", 16'h0020, word_cnt);
		chk_val("program stall", 16'h0001, {15'h0000, st_ok});
		chk_val("program flag", 16'h0001, {15'h0000, op_p});
		chk_val("program no erase", 16'h0000, {15'h0000, op_e});
		chk_val("program row", 16'h0002, {6'h00, op_row});
		for (int i = 0; i < 32; i++) begin
			ex = (i == 3) ? 16'h2a5c : (i == 7) ? 16'h1c3e : (i == 9) ? 16'h0b71 : 16'h3fff;
			chk_val("row word", ex, {2'b00, row_img[i]});
		end
		ld(15'h005f, 14'h0001);
		go(8'h04, 1'b0);
		chk_val("latches blank", 16'h3fff, {2'b00, row_img[3]});
		chk_val("last latch", 16'h0001, {2'b00, row_img[31]});
		$display("test program done");
		go(8'h04, 1'b1);
		chk_val("broken key", 16'h0000, nop_cnt + word_cnt);
		rd(CT, d, r);
		chk_reg("error flag", 8'h08, d & 8'h08);
		go(8'h00, 1'b0);
		chk_val("write disabled", 16'h0000, nop_cnt + stall_cnt);
		$display("test refusals done");
		results();
	end
endmodule
`default_nettype wire

//--- flash_seq_pkg.sv
// Constants, types and decode helper for the flash self-programming sequencer
`default_nettype none
package flash_seq_pkg;
	localparam int ADDR_W = 5;
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_KEY = 5'h04;
	localparam logic [4:0] OFS_ADDR_LO = 5'h08;
	localparam logic [4:0] OFS_ADDR_HI = 5'h0c;
	localparam logic [4:0] OFS_DATA_LO = 5'h10;
	localparam logic [4:0] OFS_DATA_HI = 5'h14;
	localparam logic [4:0] OFS_STATUS = 5'h18;
	localparam int B_RD = 0;
	localparam int B_WR = 1;
	localparam int B_WRITE_ENABLE_BIT = 2;
	localparam int B_WRERR = 3;
	localparam int B_FREE = 4;
	localparam int B_LATCH_LOAD_ONLY = 5;
	localparam int B_CONFIG_SPACE_SELECT = 6;
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;
	localparam logic [13:0] BLANK_WORD = 14'h3fff;
	localparam int NUM_LATCH = 32;
	localparam int IDX_W = 5;
	localparam int ROW_W = 10;
	localparam int CNT_W = 19;
	localparam int SETUP_CYC = 2;
	localparam int READ_CYC = 2;
	localparam int CLK_PERIOD_NS = 5;
	localparam int T_ERASE_NS = 2_000_000;
	localparam int T_PROG_NS = 2_000_000;
	localparam int ERASE_CYC = T_ERASE_NS / CLK_PERIOD_NS;
	localparam int PROG_CYC = T_PROG_NS / CLK_PERIOD_NS;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {
		st_idle = 3'b000,
		st_setup = 3'b001,
		st_erase = 3'b010,
		st_prog = 3'b011,
		st_done = 3'b100
	} seq_state_t;

	function automatic logic reg_hit(input logic [4:0] a);
		return (a[1:0] == 2'b00) && (a <= OFS_STATUS);
	endfunction
endpackage
`default_nettype wire

//--- write_latch_bank.sv
// Bank of 32 word-wide write latches with blank reset
`timescale 1ns/10ps
`default_nettype none
module write_latch_bank (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clr,
	input wire logic ld,
	input wire logic [4:0] ld_idx,
	input wire logic [13:0] ld_data,
	input wire logic [4:0] rd_idx,
	output logic [13:0] rd_word
);
	typedef struct packed {
		logic [flash_seq_pkg::NUM_LATCH-1:0][13:0] word;
	} bank_t;
	bank_t q, d;

	always_comb begin
		d = q;
		for (int i = 0; i < flash_seq_pkg::NUM_LATCH; i++) begin
			if (clr)
				d.word[i] = flash_seq_pkg::BLANK_WORD;
			else if (ld && ld_idx == i[4:0])
				d.word[i] = ld_data;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			q <= {flash_seq_pkg::NUM_LATCH{flash_seq_pkg::BLANK_WORD}};
		else
			q <= d;
	end

	assign rd_word = q.word[rd_idx];

	property p_latch_load;
		@(posedge aclk) disable iff (!aresetn)
		(ld && !clr) |=> (q.word[$past(ld_idx)] == $past(ld_data));
	endproperty
	a_latch_load: assert property (p_latch_load) else $error("latch did not take loaded word");
endmodule
`default_nettype wire
